// *** common/pcd_pair_if.sv ***
// pcd_pair_if: prescale value out to a pair prescaler, its tick back.
// assumes: both ends on i_clk_sys.
interface pcd_pair_if;
   logic [7:0] prescale;
   logic pre_tick;

   modport prescaler (input prescale, output pre_tick);
   modport owner (output prescale, input pre_tick);
endinterface

// *** common/pcd_pkg.sv ***
// pcd_pkg: offsets, field positions, reset values and divider codes
// for the pwm clock prescale / dead-zone block.
// assumes: one 100 MHz clock, synchronous active-high reset.
package pcd_pkg;

   // register byte offsets (low address bits only are decoded)
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_PRESCALE_DEADZONE = 12'h000;
   localparam logic [11:0] ADDR_DIVIDER_SELECT = 12'h004;

   // reset values
   localparam logic [31:0] RST_PRESCALE_DEADZONE = 32'h00000000;
   localparam logic [31:0] RST_DIVIDER_SELECT = 32'h00000000;

   // field positions of the prescale / dead-zone register
   localparam int PRESCALE_PAIR_LO_LSB = 0;
   localparam int PRESCALE_PAIR_HI_LSB = 8;
   localparam int DEADZONE_PAIR_LO_LSB = 16;
   localparam int DEADZONE_PAIR_HI_LSB = 24;

   // field positions of the divider select register, timer 0..3
   localparam int DIVIDER_SEL_LSB_STEP = 4;
   localparam logic [31:0] DIVIDER_SELECT_WMASK = 32'h00007777;

   // divider selection codes
   localparam logic [2:0] DIV_CODE_BY2 = 3'h0;
   localparam logic [2:0] DIV_CODE_BY4 = 3'h1;
   localparam logic [2:0] DIV_CODE_BY8 = 3'h2;
   localparam logic [2:0] DIV_CODE_BY16 = 3'h3;
   localparam logic [2:0] DIV_CODE_BY1 = 3'h4;

   // divider terminal counts (ratio minus one)
   localparam logic [3:0] DIV_LIMIT_BY1 = 4'h0;
   localparam logic [3:0] DIV_LIMIT_BY2 = 4'h1;
   localparam logic [3:0] DIV_LIMIT_BY4 = 4'h3;
   localparam logic [3:0] DIV_LIMIT_BY8 = 4'h7;
   localparam logic [3:0] DIV_LIMIT_BY16 = 4'hF;

   // ahb-lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // ratio minus one for a divider code; undefined codes divide by 1
   function automatic logic [3:0] pcd_div_limit(input logic [2:0] code);
      logic [3:0] lim;
      lim = DIV_LIMIT_BY1;
      case (code)
         DIV_CODE_BY2: lim = DIV_LIMIT_BY2;
         DIV_CODE_BY4: lim = DIV_LIMIT_BY4;
         DIV_CODE_BY8: lim = DIV_LIMIT_BY8;
         DIV_CODE_BY16: lim = DIV_LIMIT_BY16;
         default: lim = DIV_LIMIT_BY1;
      endcase
      return lim;
   endfunction

endpackage

// *** design/pcd_divider.sv ***
// pcd_divider: divides prescaler ticks by 1, 2, 4, 8 or 16.
// assumes: i_pre_tick is a one-cycle pulse on i_clk_sys.
module pcd_divider
   import pcd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [2:0] i_sel,
   input wire logic i_pre_tick,
   output logic o_tick
);

   typedef struct packed {
      logic [3:0] cnt;
      logic tick;
   } pcd_div_state_t;

   pcd_div_state_t state_reg;
   pcd_div_state_t state_next;
   logic [3:0] limit;

   // one output tick per limit+1 input ticks
   always_comb begin
      limit = pcd_div_limit(i_sel);
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (i_pre_tick) begin
         if (state_reg.cnt >= limit) begin
            state_next.cnt = 4'h0;
            state_next.tick = 1'b1;
         end else begin
            state_next.cnt = state_reg.cnt + 4'h1;
         end
      end
   end

   // state register
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_tick = state_reg.tick;

endmodule

// *** design/pcd_prescaler.sv ***
// pcd_prescaler: divides the system clock by prescale+1 as a tick; prescale zero gives no tick.
// assumes: prescale is stable-ish; a change takes effect in the running period.
module pcd_prescaler
   import pcd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   pcd_pair_if.prescaler pair
);

   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } pcd_pres_state_t;

   pcd_pres_state_t state_reg;
   pcd_pres_state_t state_next;

   // count to prescale then tick; zero prescale holds the tick low
   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (pair.prescale == 8'h00) begin
         state_next.cnt = 8'h00;
      end else if (state_reg.cnt >= pair.prescale) begin
         state_next.cnt = 8'h00;
         state_next.tick = 1'b1;
      end else begin
         state_next.cnt = state_reg.cnt + 8'h01;
      end
   end

   // state register
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pair.pre_tick = state_reg.tick;

endmodule

// *** design/pcd_top.sv ***
// pcd_top: clock prescalers, per-timer dividers and dead-zone timing
// for a four-channel pwm group, with an ahb-lite register slave.
// assumes: single ahb-lite master, whole-word transfers, one clock.
//
// The AHB-Lite interface to the registers was decided locally.
module pcd_top
   import pcd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic [1:0] i_dz_start,
   output logic o_hreadyout,
   output logic [31:0] o_hrdata,
   output logic o_hresp,
   output logic [1:0] o_pair_tick,
   output logic [3:0] o_timer_tick,
   output logic [1:0] o_dz_unit_tick,
   output logic [1:0] o_dz_busy
);

   typedef struct packed {
      logic [31:0] prescale_deadzone;
      logic [31:0] divider_select;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
      logic ready;
      logic resp;
      logic [1:0] pair_tick;
      logic [3:0] timer_tick;
      logic [1:0] unit_tick;
      logic [7:0] dz_cnt_lo;
      logic [7:0] dz_cnt_hi;
      logic [1:0] dz_busy;
   } pcd_top_state_t;

   pcd_top_state_t state_reg;
   pcd_top_state_t state_next;

   pcd_pair_if pair_if [2] ();
   logic [1:0] pre_tick;
   logic [3:0] div_tick;
   logic [11:0] req_addr;
   logic req_valid;
   logic [31:0] fwd_prescale;
   logic [31:0] fwd_divsel;
   logic [31:0] dz_interval;
   logic [7:0] dz_lo_ivl;
   logic [7:0] dz_hi_ivl;

   // prescale fields drive the two pair prescalers
   assign pair_if[0].prescale = state_reg.prescale_deadzone[
      PRESCALE_PAIR_LO_LSB +: 8];
   assign pair_if[1].prescale = state_reg.prescale_deadzone[
      PRESCALE_PAIR_HI_LSB +: 8];

   // one prescaler per pair and one divider per timer
   generate
      for (genvar p = 0; p < 2; p++) begin : g_pair
         pcd_prescaler u_prescaler (
            .i_clk_sys(i_clk_sys),
            .i_reset(i_reset),
            .pair(pair_if[p])
         );
         assign pre_tick[p] = pair_if[p].pre_tick;
         for (genvar t = 0; t < 2; t++) begin : g_timer
            // timer 2p+t divides its own pair's prescaler output
            pcd_divider u_divider (
               .i_clk_sys(i_clk_sys),
               .i_reset(i_reset),
               .i_sel(state_reg.divider_select[
                  (2 * p + t) * DIVIDER_SEL_LSB_STEP +: 3]),
               .i_pre_tick(pre_tick[p]),
               .o_tick(div_tick[2 * p + t])
            );
         end
      end
   endgenerate

   // address phase qualification
   assign req_valid = i_hsel && i_hready && i_htrans[1];
   assign req_addr = i_haddr[ADDR_W - 1:0];

   // register values with a pending data-phase write folded in, so a
   // read right behind a write returns the new value
   always_comb begin
      fwd_prescale = state_reg.prescale_deadzone;
      fwd_divsel = state_reg.divider_select;
      if (state_reg.wr_pend) begin
         if (state_reg.wr_addr == ADDR_PRESCALE_DEADZONE) begin
            fwd_prescale = i_hwdata;
         end
         if (state_reg.wr_addr == ADDR_DIVIDER_SELECT) begin
            fwd_divsel = i_hwdata & DIVIDER_SELECT_WMASK;
         end
      end
   end

   // dead-zone intervals as held for software
   assign dz_interval = state_reg.prescale_deadzone;
   assign dz_lo_ivl = dz_interval[DEADZONE_PAIR_LO_LSB +: 8];
   assign dz_hi_ivl = dz_interval[DEADZONE_PAIR_HI_LSB +: 8];

   // bus slave, register update and dead-zone timing
   always_comb begin
      state_next = state_reg;
      state_next.ready = 1'b1;
      state_next.resp = HRESP_OKAY;
      // data phase write: commit i_hwdata to the register addressed in the address phase
      if (state_reg.wr_pend) begin
         state_next.prescale_deadzone = fwd_prescale;
         state_next.divider_select = fwd_divsel;
      end
      state_next.wr_pend = 1'b0;
      // address phase: latch writes, fetch read data for next cycle
      if (req_valid) begin
         state_next.wr_pend = i_hwrite;
         state_next.wr_addr = req_addr;
         state_next.rdata = 32'h00000000;
         if (!i_hwrite) begin
            case (req_addr)
               ADDR_PRESCALE_DEADZONE: state_next.rdata = fwd_prescale;
               ADDR_DIVIDER_SELECT: state_next.rdata = fwd_divsel;
               default: state_next.rdata = 32'h00000000;
            endcase
         end
      end
      // tick outputs straight from the prescalers and dividers
      state_next.pair_tick = pre_tick;
      state_next.timer_tick = div_tick;
      // one dead-zone unit per even-timer divided tick of the pair
      state_next.unit_tick = {div_tick[2], div_tick[0]};
      // pair 0/1 dead zone: load interval, count down in units
      if (i_dz_start[0]) begin
         state_next.dz_cnt_lo = dz_lo_ivl;
      end else if (div_tick[0] && state_reg.dz_cnt_lo != 8'h00) begin
         state_next.dz_cnt_lo = state_reg.dz_cnt_lo - 8'h01;
      end
      // pair 2/3 dead zone: load interval, count down in units
      if (i_dz_start[1]) begin
         state_next.dz_cnt_hi = dz_hi_ivl;
      end else if (div_tick[2] && state_reg.dz_cnt_hi != 8'h00) begin
         state_next.dz_cnt_hi = state_reg.dz_cnt_hi - 8'h01;
      end
      state_next.dz_busy[0] = state_next.dz_cnt_lo != 8'h00;
      state_next.dz_busy[1] = state_next.dz_cnt_hi != 8'h00;
   end

   // state register
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_reg <= '0;
         state_reg.prescale_deadzone <= RST_PRESCALE_DEADZONE;
         state_reg.divider_select <= RST_DIVIDER_SELECT;
      end else begin
         state_reg <= state_next;
      end
   end

   // every output comes from the state register
   assign o_hreadyout = state_reg.ready;
   assign o_hrdata = state_reg.rdata;
   assign o_hresp = state_reg.resp;
   assign o_pair_tick = state_reg.pair_tick;
   assign o_timer_tick = state_reg.timer_tick;
   assign o_dz_unit_tick = state_reg.unit_tick;
   assign o_dz_busy = state_reg.dz_busy;

endmodule

// *** sim/pcd_props.sv ***
// pcd_props: bus, prescaler and dead-zone checks on pcd_top ports.
// assumes: one clock, synchronous active-high reset, zero-wait slave.
module pcd_props
   import pcd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic [1:0] i_dz_start,
   input wire logic [31:0] o_hrdata,
   input wire logic [1:0] o_pair_tick,
   input wire logic [1:0] o_dz_busy
);
   logic ph_w, ph_r;
   logic [11:0] ph_a;
   logic [31:0] sh_pd;
   logic [1:0] zc0, zc1;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);

   // shadow of the data phase, the prescale register and zero spells
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         ph_w <= 1'b0;
         ph_r <= 1'b0;
         ph_a <= 12'h000;
         sh_pd <= 32'h00000000;
         zc0 <= 2'h0;
         zc1 <= 2'h0;
      end else begin
         ph_w <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
         ph_r <= i_hsel && i_hready && i_htrans[1] && !i_hwrite;
         ph_a <= i_haddr[11:0];
         if (ph_w && i_hready && ph_a == ADDR_PRESCALE_DEADZONE)
            sh_pd <= i_hwdata;
         zc0 <= (sh_pd[7:0] != 8'h00) ? 2'h0 : zc0 + {1'b0, zc0 != 2'h3};
         zc1 <= (sh_pd[15:8] != 8'h00) ? 2'h0 : zc1 + {1'b0, zc1 != 2'h3};
      end
   end

   a_pulse_lo: assert property (o_pair_tick[0] |=> !o_pair_tick[0])
      else $error("pair lo tick longer than one cycle");
   a_pulse_hi: assert property (o_pair_tick[1] |=> !o_pair_tick[1])
      else $error("pair hi tick longer than one cycle");
   a_zero_stop: assert property (zc0 == 2'h3 |-> !o_pair_tick[0])
      else $error("pair lo ticks with prescale zero");
   a_hi_stop: assert property (zc1 == 2'h3 |-> !o_pair_tick[1])
      else $error("pair hi ticks with prescale zero");
   a_read_back: assert property (
      ph_r && ph_a == ADDR_PRESCALE_DEADZONE |-> o_hrdata == sh_pd)
      else $error("prescale read differs");
   a_read_mask: assert property (
      ph_r && ph_a == ADDR_DIVIDER_SELECT
      |-> (o_hrdata & ~32'h00007777) == 32'h0) else $error("reserved set");
   a_dz_load: assert property (
      i_dz_start[0] && sh_pd[23:16] != 8'h00
      |=> o_dz_busy[0]) else $error("dead zone lo did not start");
   a_dz_zero: assert property (
      i_dz_start[1] && sh_pd[31:24] == 8'h00
      && !o_dz_busy[1] |=> !o_dz_busy[1]) else $error("dead zone hi busy");
   a_busy_cause: assert property ($rose(o_dz_busy[0])
      |-> $past(i_dz_start[0])) else $error("dead zone lo without start");
endmodule

bind pcd_top pcd_props u_props (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
   .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .i_dz_start(i_dz_start), .o_hrdata(o_hrdata),
   .o_pair_tick(o_pair_tick), .o_dz_busy(o_dz_busy));

// *** sim/test_pwm_clock_prescale_deadzone.sv ***
// testbench for pcd_top: register access, tick periods, dead zone.
// assumes: zero-wait ahb-lite slave, 100 MHz clock.
module test_pwm_clock_prescale_deadzone
   import pcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rdy;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata, r;
   logic [1:0] htrans = 2'h0, dz = 2'h0, pt, busy, ut;
   logic hresp;
   logic [3:0] tt;
   logic [7:0] tk;
   logic [7:0] ob;
   int err_count = 0, comparisons = 0, n, c1;
   int ratio[5] = '{2, 4, 8, 16, 1};
   assign tk = {ut, tt, pt};
   assign ob = {busy, tt, pt};

   pcd_top uut (.i_clk_sys(clk), .i_reset(rst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy),
      .i_dz_start(dz), .o_hreadyout(rdy), .o_hrdata(rdata),
      .o_hresp(hresp), .o_pair_tick(pt), .o_timer_tick(tt),
      .o_dz_unit_tick(ut), .o_dz_busy(busy));

   always #5 clk = ~clk;

   // compare, count, report a mismatch
   task automatic chk(input string s, input logic [31:0] v, e);
      comparisons++;
      if (v !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", s, e, v);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // next edge, then edges until ready is sampled high, bounded
   task automatic hwait;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
         if (k > 50) begin
            err_count++;
            end_sim();
         end
      end while (rdy !== 1'b1);
   endtask

   // one whole-word transfer; read data taken at the closing edge
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      hwait();
      htrans <= 2'h0;
      hwdata <= d;
      hwait();
      r = rdata;
   endtask

   task automatic rd(input string s, input logic [11:0] a,
                     input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(s, r, e);
      chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask

   // spacing of the 2nd and 3rd pulse of tick b, bounded wait
   task automatic per(input string s, input int b, input int e);
      int k, t0, c;
      k = 0;
      t0 = 0;
      c = 0;
      while (c < 3) begin
         @(posedge clk);
         k++;
         if (tk[b] === 1'b1) begin
            c++;
            if (c == 2)
               t0 = k;
         end
         if (k > 500) begin
            err_count++;
            end_sim();
         end
      end
      chk(s, 32'(k - t0), 32'(e));
   endtask

   // cycles within 100 where any masked output is high
   task automatic cnt(input logic [7:0] m, output int c);
      c = 0;
      repeat (100) begin
         @(posedge clk);
         if ((ob & m) !== 8'h00)
            c++;
      end
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd("pd_reset", ADDR_PRESCALE_DEADZONE,
         RST_PRESCALE_DEADZONE);
      rd("ds_reset", ADDR_DIVIDER_SELECT, RST_DIVIDER_SELECT);
      bus(1'b1, 12'h008, 32'hFFFFFFFF);
      rd("unmapped", 12'h008, 32'h00000000);
      $display("test reset values done");
      bus(1'b1, ADDR_PRESCALE_DEADZONE, 32'hA55AC33C);
      rd("pd_back", ADDR_PRESCALE_DEADZONE, 32'hA55AC33C);
      bus(1'b1, ADDR_DIVIDER_SELECT, 32'hFFFFFFFF);
      rd("ds_back", ADDR_DIVIDER_SELECT, 32'h00007777);
      $display("test register access done");
      // prescale 3 and 5; every divider code, pair partners differ
      bus(1'b1, ADDR_PRESCALE_DEADZONE, 32'h00000503);
      for (int c = 0; c < 5; c++) begin
         c1 = (c + 1) % 5;
         bus(1'b1, ADDR_DIVIDER_SELECT, {16'h0, 1'b0, 3'(c1), 1'b0,
             3'(c), 1'b0, 3'(c1), 1'b0, 3'(c)});
         per("pair_lo", 0, 4);
         per("pair_hi", 1, 6);
         per("timer0", 2, 4 * ratio[c]);
         per("timer1", 3, 4 * ratio[c1]);
         per("timer2", 4, 6 * ratio[c]);
         per("timer3", 5, 6 * ratio[c1]);
         per("unit_lo", 6, 4 * ratio[c]);
         per("unit_hi", 7, 6 * ratio[c]);
      end
      $display("test divider periods done");
      // lo interval 2 in 8-cycle units, hi interval 0
      bus(1'b1, ADDR_PRESCALE_DEADZONE, 32'h00020503);
      bus(1'b1, ADDR_DIVIDER_SELECT, 32'h00000000);
      dz <= 2'b11;
      @(posedge clk);
      dz <= 2'b00;
      cnt(8'hC0, n);
      chk("dz_length", 32'(n >= 8 && n <= 18), 32'h1);
      $display("test dead zone done");
      bus(1'b1, ADDR_PRESCALE_DEADZONE, 32'h00000000);
      repeat (3) @(posedge clk);
      cnt(8'h3F, n);
      chk("stopped_ticks", 32'(n), 32'h0);
      $display("test prescale stop done");
      end_sim();
   end
endmodule
